// ===== tb/opr_top_chk.sv
// Port assertions for the output register bank.
`timescale 1ns/1ps
module opr_top_chk (
	input wire logic        core_clk,
	input wire logic        srst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [9:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic [3:0]  wb_sel_i,
	input wire logic        wb_ack_o,
	input wire logic        differential_out_a_oe,
	input wire logic        differential_out_b_oe,
	input wire logic        feedback_clock_out_oe,
	input wire logic [21:0] frame_pulse_b_offset,
	input wire logic [7:0]  fp_phase_offset_mid,
	input wire logic [7:0]  diff_out_a_skew_cycles,
	input wire logic [1:0]  diff_out_a_skew
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	// Request taken while no answer is pending
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	// Enabled byte write to one address
	sequence s_wr(a);
		s_take ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == a);
	endsequence
	property p_ack; s_take |=> wb_ack_o ##1 !wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack not one pulse");
	property p_rdz; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
	a_rdz: assert property (p_rdz) else $error("upper read bits");
	property p_mid; s_wr(10'h178) |=> ##1
		fp_phase_offset_mid == $past(wb_dat_i[7:0], 2); endproperty
	a_mid: assert property (p_mid) else $error("mid byte");
	property p_join; frame_pulse_b_offset[15:8] == fp_phase_offset_mid;
	endproperty
	a_join: assert property (p_join) else $error("offset join");
	property p_en; s_wr(10'h180) |=> ##1 {differential_out_b_oe,
		differential_out_a_oe} == $past(wb_dat_i[1:0], 2); endproperty
	a_en: assert property (p_en) else $error("diff enables");
	property p_skw; s_wr(10'h180) |=> ##1
		diff_out_a_skew == $past(wb_dat_i[5:4], 2); endproperty
	a_skw: assert property (p_skw) else $error("skew a");
	property p_cyc;
		diff_out_a_skew_cycles == {2'b00, diff_out_a_skew, 4'h0};
	endproperty
	a_cyc: assert property (p_cyc) else $error("skew tenths");
	property p_fb; s_wr(10'h188) |=> ##1
		feedback_clock_out_oe == $past(wb_dat_i[0], 2); endproperty
	a_fb: assert property (p_fb) else $error("feedback enable");
	property p_rst; $fell(srst) |=> differential_out_a_oe &&
		differential_out_b_oe && !feedback_clock_out_oe; endproperty
	a_rst: assert property (p_rst) else $error("reset enables");
endmodule : opr_top_chk

// ===== tb/opr_top_tb.sv
// Self-checking bench for the output register bank.
`timescale 1ns/1ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin errors++; \
	$display("unexpected %s exp %0h got %0h", n, e, a); end end
module opr_top_tb;
	import opr_pkg::*;
	logic        core_clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0;
	logic        we = 1'b0, ack, oe_a, oe_b, fb_oe, f311;
	logic [9:0]  adr = 10'h0;
	logic [31:0] dat = 32'h0, rd;
	logic [3:0]  sel = 4'h0;
	logic [7:0]  low = 8'h3c, mid, cyc_a, cyc_b, q;
	logic [21:0] ofs;
	logic [5:0]  crs;
	logic [1:0]  sk_a, sk_b;
	logic [2:0]  fs_a, fs_b;
	opr_family_t fam = OPR_FAM_648;
	int          errors = 0, comparisons = 0, ticks = 0;
	opr_top dut_u (.core_clk(core_clk), .srst(srst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
		.wb_sel_i(sel), .wb_dat_o(rd), .wb_ack_o(ack),
		.fp_phase_offset_low(low), .ref_family(fam),
		.frame_pulse_b_offset(ofs), .fp_phase_offset_mid(mid),
		.fp_phase_offset_coarse(crs), .fine_step_is_311(f311),
		.differential_out_a_oe(oe_a), .differential_out_b_oe(oe_b),
		.diff_out_a_skew(sk_a), .diff_out_b_skew(sk_b),
		.diff_out_a_skew_cycles(cyc_a), .diff_out_b_skew_cycles(cyc_b),
		.diff_out_a_freq_sel(fs_a), .diff_out_b_freq_sel(fs_b),
		.feedback_clock_out_oe(fb_oe));
	// 8 ns clock
	initial forever #4 core_clk = ~core_clk;
	// Hang guard: whole run needs under a hundred cycles
	always @(posedge core_clk) begin
		ticks++;
		if (ticks == 3000) begin
			errors++;
			end_sim();
		end
	end
	// One Wishbone classic access; read byte lands in q
	task automatic acc(input logic w, input logic [7:0] i,
		input logic [7:0] d, input logic [3:0] s);
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= s;
		adr <= {i, 2'b00};
		dat <= {24'h0, d};
		do @(posedge core_clk); while (ack !== 1'b1);
		q = rd[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : acc
	// Read one register and compare
	task automatic rc(input string n, input logic [7:0] i, e);
		acc(1'b0, i, 8'h00, 4'h1);
		`CHK(n, e, q)
	endtask : rc
	task t_reset;
		rc("mid", IDX_PHASE_MID, 8'h00);
		rc("coarse", IDX_PHASE_COARSE, 8'h00);
		rc("ctrl", IDX_DIFF_CTRL, 8'ha3);
		rc("sel", IDX_DIFF_SEL, 8'h53);
		rc("fb", IDX_FB_CTRL, 8'h80);
		`CHK("oe_a", 1'b1, oe_a)
		`CHK("oe_b", 1'b1, oe_b)
		`CHK("fs_a", 3'd3, fs_a)
		`CHK("fs_b", 3'd5, fs_b)
		`CHK("fb_oe", 1'b0, fb_oe)
		$display("test reset done");
	endtask : t_reset
	// Coarse top bits are reserved and must read back as zero
	task t_offset;
		acc(1'b1, IDX_PHASE_MID, 8'ha5, 4'h1);
		acc(1'b1, IDX_PHASE_COARSE, 8'hff, 4'h1);
		acc(1'b1, IDX_PHASE_MID, 8'h11, 4'h0);
		rc("mid", IDX_PHASE_MID, 8'ha5);
		rc("coarse", IDX_PHASE_COARSE, 8'h3f);
		`CHK("offset", {6'h3f, 8'ha5, 8'h3c}, ofs)
		`CHK("crs", 6'h3f, crs)
		`CHK("mid_out", 8'ha5, mid)
		rc("unmapped", 8'h00, 8'h00);
		$display("test offset done");
	endtask : t_offset
	// Two control patterns cover skew values 1 and 3 and both enable states
	task t_ctrl;
		acc(1'b1, IDX_DIFF_CTRL, 8'h5c, 4'h1);
		rc("ctrl", IDX_DIFF_CTRL, 8'h50);
		`CHK("oe", 2'b00, {oe_b, oe_a})
		`CHK("sk_b", 2'd1, sk_b)
		`CHK("cyc_b", 8'h10, cyc_b)
		acc(1'b1, IDX_DIFF_CTRL, 8'hff, 4'h1);
		rc("ctrl", IDX_DIFF_CTRL, 8'hf3);
		`CHK("oe", 2'b11, {oe_b, oe_a})
		`CHK("sk_a", 2'd3, sk_a)
		`CHK("cyc_a", 8'h30, cyc_a)
		acc(1'b1, IDX_DIFF_SEL, 8'hfe, 4'h1);
		rc("sel", IDX_DIFF_SEL, 8'h76);
		`CHK("fs", 6'o76, {fs_b, fs_a})
		acc(1'b1, IDX_FB_CTRL, 8'hff, 4'h1);
		rc("fb", IDX_FB_CTRL, 8'h81);
		`CHK("fb_oe", 1'b1, fb_oe)
		acc(1'b1, IDX_FB_CTRL, 8'h00, 4'h1);
		rc("fb", IDX_FB_CTRL, 8'h80);
		`CHK("fb_oe", 1'b0, fb_oe)
		$display("test ctrl done");
	endtask : t_ctrl
	// Reset in mid-run must bring the written mid, coarse and ctrl registers back to defaults
	task t_rerun;
		srst <= 1'b1;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		rc("mid", IDX_PHASE_MID, 8'h00);
		rc("coarse", IDX_PHASE_COARSE, 8'h00);
		rc("ctrl", IDX_DIFF_CTRL, 8'ha3);
		`CHK("offset", {6'h00, 8'h00, 8'h3c}, ofs)
		`CHK("mid_out", 8'h00, mid)
		`CHK("fb_oe", 1'b0, fb_oe)
		$display("test rerun done");
	endtask : t_rerun
	task t_family;
		fam <= OPR_FAM_1944;
		repeat (3) @(posedge core_clk);
		`CHK("f311", 1'b1, f311)
		fam <= OPR_FAM_648;
		repeat (3) @(posedge core_clk);
		`CHK("f311", 1'b0, f311)
		$display("test family done");
	endtask : t_family
	task end_sim;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	initial begin
		repeat (8) @(posedge core_clk);
		srst <= 1'b0;
		t_reset();
		t_offset();
		t_ctrl();
		t_rerun();
		t_family();
		end_sim();
	end
endmodule : opr_top_tb
bind opr_top opr_top_chk chk_u (.core_clk(core_clk), .srst(srst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o),
	.differential_out_a_oe(differential_out_a_oe),
	.differential_out_b_oe(differential_out_b_oe),
	.feedback_clock_out_oe(feedback_clock_out_oe),
	.frame_pulse_b_offset(frame_pulse_b_offset),
	.fp_phase_offset_mid(fp_phase_offset_mid),
	.diff_out_a_skew_cycles(diff_out_a_skew_cycles),
	.diff_out_a_skew(diff_out_a_skew));

// ===== verilog/opr_bus_if.sv
// Interface carrying one decoded register write and read request.
`timescale 1ns/1ps
interface opr_bus_if;
	logic       wr_en;   // One-cycle write strobe
	logic [7:0] index;   // Register index
	logic [7:0] wr_data; // Write byte
	logic       hit;     // Index maps to a held register
	logic [7:0] rd_data; // Registered read byte
	modport master (output wr_en, index, wr_data, input hit, rd_data);
	modport slave (input wr_en, index, wr_data, output hit, rd_data);
endinterface : opr_bus_if

// ===== verilog/opr_pkg.sv
// Package of offsets, field positions, reset values and timing constants.
package opr_pkg;
	// ****************************************************************
	// Register word indices (printed offsets are not multiples of four)
	// ****************************************************************
	localparam logic [7:0] IDX_PHASE_LOW    = 8'h5d; // Low byte index
	localparam logic [7:0] IDX_PHASE_MID    = 8'h5e; // Offset bits 15:8
	localparam logic [7:0] IDX_PHASE_COARSE = 8'h5f; // Offset bits 21:16
	localparam logic [7:0] IDX_DIFF_CTRL    = 8'h60; // Enables and skews
	localparam logic [7:0] IDX_DIFF_SEL     = 8'h61; // Frequency selects
	localparam logic [7:0] IDX_FB_CTRL      = 8'h62; // Feedback control

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] RST_PHASE_MID    = 8'h00;
	localparam logic [7:0] RST_PHASE_COARSE = 8'h00;
	localparam logic [7:0] RST_DIFF_CTRL    = 8'ha3;
	localparam logic [7:0] RST_DIFF_SEL     = 8'h53;
	localparam logic [7:0] RST_FB_CTRL      = 8'h80;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int COARSE_LSB   = 0;  // Coarse field 5:0
	localparam int COARSE_W     = 6;
	localparam int PHASE_W      = 22; // Whole phase offset width
	localparam int A_EN_BIT     = 0;  // First output enable
	localparam int B_EN_BIT     = 1;  // Second output enable
	localparam int A_SKEW_LSB   = 4;  // Skew field 5:4
	localparam int B_SKEW_LSB   = 6;  // Skew field 7:6
	localparam int SKEW_W       = 2;
	localparam int A_SEL_LSB    = 0;  // Select field 2:0
	localparam int B_SEL_LSB    = 4;  // Select field 6:4
	localparam int SEL_W        = 3;
	localparam int FB_EN_BIT    = 0;  // Feedback output enable

	// Writable masks; other bits hold their reset value
	localparam logic [7:0] MASK_PHASE_MID    = 8'hff;
	localparam logic [7:0] MASK_PHASE_COARSE = 8'h3f;
	localparam logic [7:0] MASK_DIFF_CTRL    = 8'hf3;
	localparam logic [7:0] MASK_DIFF_SEL     = 8'h77;
	localparam logic [7:0] MASK_FB_CTRL      = 8'h01;

	// ****************************************************************
	// Timing constants
	// ****************************************************************
	localparam real SKEW_STEP_NS = 1.6;    // One skew step
	localparam int  SKEW_STEP_X10 = 16;    // One skew step in tenths of ns
	localparam real CLK_NS       = 8.0;    // core_clk period
	localparam real FINE_A_MHZ   = 207.36; // 6.48 MHz family step
	localparam real FINE_B_MHZ   = 311.04; // 19.44 MHz family step
	localparam real FRAME_KHZ    = 8.0;    // Coarse unit rate

	// Fine step family selector
	typedef enum logic {OPR_FAM_648, OPR_FAM_1944} opr_family_t;
endpackage : opr_pkg

// ===== verilog/opr_reg_file.sv
// Byte register file with reset defaults and reserved bit masks.
`timescale 1ns/1ps
module opr_reg_file (
	input  wire logic        core_clk,
	input  wire logic        srst,
	opr_bus_if.slave         bus,
	output logic [7:0]       phase_mid,
	output logic [7:0]       phase_coarse,
	output logic [7:0]       diff_ctrl,
	output logic [7:0]       diff_sel,
	output logic [7:0]       fb_ctrl
);
	import opr_pkg::*;

	// ****************************************************************
	// Decode
	// ****************************************************************
	wire sel_mid    = (bus.index == IDX_PHASE_MID);
	wire sel_coarse = (bus.index == IDX_PHASE_COARSE);
	wire sel_dctl   = (bus.index == IDX_DIFF_CTRL);
	wire sel_dsel   = (bus.index == IDX_DIFF_SEL);
	wire sel_fb     = (bus.index == IDX_FB_CTRL);
	assign bus.hit  = sel_mid | sel_coarse | sel_dctl | sel_dsel | sel_fb;

	// Reserved bits are forced to their default, so reads return it
	function automatic logic [7:0] merge(input logic [7:0] d,
		input logic [7:0] m, input logic [7:0] r);
		merge = (d & m) | (r & ~m);
	endfunction : merge

	// Register writes
	always_ff @(posedge core_clk) begin
		if (srst) begin
			phase_mid    <= RST_PHASE_MID;
			phase_coarse <= RST_PHASE_COARSE;
			diff_ctrl    <= RST_DIFF_CTRL;
			diff_sel     <= RST_DIFF_SEL;
			fb_ctrl      <= RST_FB_CTRL;
		end else if (bus.wr_en) begin
			if (sel_mid)
				phase_mid <= bus.wr_data;
			if (sel_coarse)
				phase_coarse <= merge(bus.wr_data, MASK_PHASE_COARSE,
					RST_PHASE_COARSE);
			if (sel_dctl)
				diff_ctrl <= merge(bus.wr_data, MASK_DIFF_CTRL,
					RST_DIFF_CTRL);
			if (sel_dsel)
				diff_sel <= merge(bus.wr_data, MASK_DIFF_SEL,
					RST_DIFF_SEL);
			if (sel_fb)
				fb_ctrl <= merge(bus.wr_data, MASK_FB_CTRL, RST_FB_CTRL);
		end
	end

	// Read mux, unmapped reads as zero
	wire [7:0] rd_mux = sel_mid    ? phase_mid :
	                    sel_coarse ? phase_coarse :
	                    sel_dctl   ? diff_ctrl :
	                    sel_dsel   ? diff_sel :
	                    sel_fb     ? fb_ctrl : 8'h00;

	// Registered read data
	always_ff @(posedge core_clk) begin
		if (srst)
			bus.rd_data <= 8'h00;
		else
			bus.rd_data <= rd_mux;
	end
endmodule : opr_reg_file

// ===== verilog/opr_top.sv
// Output phase and enable register bank with a Wishbone slave port.
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps

// How it works
// - Mid phase byte, read/write, resets zero.
// - Three bytes form one 22-bit offset.
// - Coarse bits 21:16, units of 8 kHz.
// - Fine step follows reference output family.
// - Bit 0 enables first differential output.
// - Bit 1 enables second differential output.
// - Bits 5:4 skew first output, 1.6 ns.
// - Bits 7:6 skew second output, 1.6 ns.
// - Bits 2:0 select first output frequency.
// - Bits 6:4 select second output frequency.
// - Feedback bit 0 enables feedback clock.
module opr_top (
	input  wire logic                  core_clk,
	input  wire logic                  srst,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [9:0]            wb_adr_i,
	input  wire logic [31:0]           wb_dat_i,
	input  wire logic [3:0]            wb_sel_i,
	output logic [31:0]                wb_dat_o,
	output logic                       wb_ack_o,
	input  wire logic [7:0]            fp_phase_offset_low,
	input  wire opr_pkg::opr_family_t  ref_family,
	output logic [21:0]                frame_pulse_b_offset,
	output logic [7:0]                 fp_phase_offset_mid,
	output logic [5:0]                 fp_phase_offset_coarse,
	output logic                       fine_step_is_311,
	output logic                       differential_out_a_oe,
	output logic                       differential_out_b_oe,
	output logic [1:0]                 diff_out_a_skew,
	output logic [1:0]                 diff_out_b_skew,
	output logic [7:0]                 diff_out_a_skew_cycles,
	output logic [7:0]                 diff_out_b_skew_cycles,
	output logic [2:0]                 diff_out_a_freq_sel,
	output logic [2:0]                 diff_out_b_freq_sel,
	output logic                       feedback_clock_out_oe
);
	import opr_pkg::*;

	// ****************************************************************
	// Wishbone slave
	// ****************************************************************
	opr_bus_if bus ();

	logic [7:0] phase_mid;    // Held mid byte
	logic [7:0] phase_coarse; // Held coarse byte
	logic [7:0] diff_ctrl;    // Enables and skews
	logic [7:0] diff_sel;     // Frequency selects
	logic [7:0] fb_ctrl;      // Feedback control
	logic       ack_q;        // Registered ack

	// A request is new only while ack is low, so each access acks once
	wire req       = wb_cyc_i & wb_stb_i & ~ack_q;
	// Byte address is four times the index; low two bits must be zero
	wire aligned   = (wb_adr_i[1:0] == 2'b00);
	assign bus.index   = wb_adr_i[9:2];
	assign bus.wr_data = wb_dat_i[7:0];
	// Write only when byte lane 0 is selected and the word is mapped
	assign bus.wr_en   = req & wb_we_i & wb_sel_i[0] & aligned & bus.hit;

	// Ack one cycle after the request; unmapped reads give zero
	always_ff @(posedge core_clk) begin
		if (srst)
			ack_q <= 1'b0;
		else
			ack_q <= req;
	end
	assign wb_ack_o = ack_q;
	// Narrow data sits in the low byte, upper bits read zero
	assign wb_dat_o = {24'h000000, bus.rd_data};

	opr_reg_file u_regs (
		.core_clk     (core_clk),
		.srst         (srst),
		.bus          (bus.slave),
		.phase_mid    (phase_mid),
		.phase_coarse (phase_coarse),
		.diff_ctrl    (diff_ctrl),
		.diff_sel     (diff_sel),
		.fb_ctrl      (fb_ctrl)
	);

	// ****************************************************************
	// Derived controls
	// ****************************************************************
	// Skew in tenths of a nanosecond, data stage uses this directly
	wire [7:0] a_skew_t = 8'(diff_ctrl[A_SKEW_LSB +: SKEW_W]
		* SKEW_STEP_X10);
	wire [7:0] b_skew_t = 8'(diff_ctrl[B_SKEW_LSB +: SKEW_W]
		* SKEW_STEP_X10);

	// Assemble full offset; low byte comes from the neighbouring register
	wire [21:0] full_off = {phase_coarse[COARSE_LSB +: COARSE_W],
		phase_mid, fp_phase_offset_low};

	// Output registers; the clock stage reads these every cycle
	always_ff @(posedge core_clk) begin
		if (srst) begin
			frame_pulse_b_offset   <= 22'h000000;
			fp_phase_offset_mid    <= 8'h00;
			fp_phase_offset_coarse <= 6'h00;
			fine_step_is_311       <= 1'b0;
			differential_out_a_oe  <= 1'b0;
			differential_out_b_oe  <= 1'b0;
			diff_out_a_skew        <= 2'b00;
			diff_out_b_skew        <= 2'b00;
			diff_out_a_skew_cycles <= 8'h00;
			diff_out_b_skew_cycles <= 8'h00;
			diff_out_a_freq_sel    <= 3'h0;
			diff_out_b_freq_sel    <= 3'h0;
			feedback_clock_out_oe  <= 1'b0;
		end else begin
			frame_pulse_b_offset   <= full_off;
			fp_phase_offset_mid    <= phase_mid;
			fp_phase_offset_coarse <= phase_coarse[COARSE_LSB +:
				COARSE_W];
			// Fine unit 1/311.04 MHz in 19.44 family else 1/207.36
			fine_step_is_311 <= (ref_family == OPR_FAM_1944);
			differential_out_a_oe <= diff_ctrl[A_EN_BIT];
			differential_out_b_oe <= diff_ctrl[B_EN_BIT];
			diff_out_a_skew <= diff_ctrl[A_SKEW_LSB +: SKEW_W];
			diff_out_b_skew <= diff_ctrl[B_SKEW_LSB +: SKEW_W];
			diff_out_a_skew_cycles <= a_skew_t;
			diff_out_b_skew_cycles <= b_skew_t;
			diff_out_a_freq_sel <= diff_sel[A_SEL_LSB +: SEL_W];
			diff_out_b_freq_sel <= diff_sel[B_SEL_LSB +: SEL_W];
			feedback_clock_out_oe <= fb_ctrl[FB_EN_BIT];
		end
	end
endmodule : opr_top
